// ===== src/measurement_command_sequencer.sv
// Command sequencer for overlapped/sequential instrument commands with an AXI4-Lite register port.
`timescale 1ns/1ps

// Contract
// - Sequential command completes all its steps before the next command starts.
// - Wait command holds later commands until all overlapped operations complete.
// - Only initiate, continuous-on and bus trigger are overlapped; others sequential.
// - Initiate leaves idle; it completes only on return to idle.
// - Wait after bus trigger releases once trigger position settles.
// - Configure selects one of eleven functions; query returns current function.
// - Configure restores function defaults and turns continuous initiation off.
// - Configure sets immediate source, counts one, zero delay, enters idle.
// - Configure disables math, buffer storage, scanning; restores autozero default.
// - Fetch returns latest reading without triggering or changing setup.
// - Reading goes to host only after host addresses device to talk.
// - Repeated fetch returns the same reading until a new one arrives.
// - Read runs abort, initiate, fetch in strict order.
// - Read acquires sample-count readings and stores them in the buffer.
// - Abort idles when continuous off, restarts trigger model when on; the code only pulses the engine abort in both cases.
// - Initiate with continuous on is ignored and raises an error.
// - Ignored-initiate error inside read does not stop its fetch.
// - Read refused with -225 when sample count above one and buffer nonempty.
// - Measure runs abort, configure, then the full read sequence.
module measurement_command_sequencer (
  input wire logic aclk, // 200 MHz system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic talk_addressed, // host has addressed device to talk (pin)
  input wire logic engine_idle, // measurement engine is idle
  input wire logic trig_settled, // trigger-model position has settled
  input wire logic reading_valid, // new post-processed reading strobe
  input wire logic [31:0] reading_data, // post-processed reading value
  input wire logic buffer_nonempty, // buffer holds readings
  output mcs_pkg::engine_cmd_t engine_cmd, // abort/start/trigger pulses and sample count
  output mcs_pkg::setup_t setup, // instrument setup image
  output logic pending_op // an overlapped operation is in progress
);

  // --------
  // Input synchronisers for the talk-address pin
  // --------
  logic talk_meta_ff;
  logic talk_sync_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      talk_meta_ff <= 1'b0;
      talk_sync_ff <= 1'b0;
    end else begin
      talk_meta_ff <= talk_addressed;
      talk_sync_ff <= talk_meta_ff;
    end
  end

  // --------
  // AXI4-Lite write channel
  // --------
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic cmd_busy;
  logic wr_fire;
  logic cmd_write;

  // A command write is held off while the sequencer is busy; that is the back-pressure.
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff && !(awaddr_ff == mcs_pkg::REG_CMD && cmd_busy);
  assign cmd_write = wr_fire && awaddr_ff == mcs_pkg::REG_CMD;
  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= mcs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      case (awaddr_ff)
        mcs_pkg::REG_CMD, mcs_pkg::REG_SAMPLES, mcs_pkg::REG_ERROR: bresp_ff <= mcs_pkg::RESP_OKAY;
        mcs_pkg::REG_STATUS, mcs_pkg::REG_CONFIG, mcs_pkg::REG_RESULT: bresp_ff <= mcs_pkg::RESP_SLVERR;
        default: bresp_ff <= mcs_pkg::RESP_DECERR;
      endcase
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // --------
  // Software settings
  // --------
  logic [15:0] samples_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samples_ff <= mcs_pkg::SAMPLES_RST;
    end else if (wr_fire && awaddr_ff == mcs_pkg::REG_SAMPLES) begin
      if (wstrb_ff[0]) samples_ff[7:0] <= wdata_ff[7:0];
      if (wstrb_ff[1]) samples_ff[15:8] <= wdata_ff[15:8];
    end
  end

  // --------
  // Command sequencer
  // --------
  mcs_pkg::seq_state_t state_ff;
  mcs_pkg::op_t op_ff;
  logic [3:0] func_ff;
  logic measure_ff;
  logic read_ff;
  logic init_pending_ff;
  logic trig_pending_ff;
  logic [31:0] error_ff;
  logic [31:0] latest_ff;
  logic [31:0] result_ff;
  logic result_ready_ff;
  logic fetch_req_ff;
  logic engine_abort_ff;
  logic engine_start_ff;
  logic engine_trig_ff;
  mcs_pkg::setup_t setup_ff;
  logic set_err;
  logic [31:0] set_err_code;

  assign cmd_busy = state_ff != mcs_pkg::ST_IDLE;
  assign pending_op = init_pending_ff || trig_pending_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= mcs_pkg::ST_IDLE;
      op_ff <= mcs_pkg::OP_NOP;
      func_ff <= mcs_pkg::FUNC_RST;
      measure_ff <= 1'b0;
      read_ff <= 1'b0;
    end else begin
      case (state_ff)
        mcs_pkg::ST_IDLE: begin
          if (cmd_write) begin
            op_ff <= mcs_pkg::op_t'(wdata_ff[mcs_pkg::CMD_OP_LSB +: 4]);
            func_ff <= wdata_ff[mcs_pkg::CMD_FUNC_LSB +: 4];
            state_ff <= mcs_pkg::ST_DECODE;
          end
        end
        mcs_pkg::ST_DECODE: begin
          measure_ff <= op_ff == mcs_pkg::OP_MEASURE;
          read_ff <= op_ff == mcs_pkg::OP_READ || op_ff == mcs_pkg::OP_MEASURE;
          case (op_ff)
            mcs_pkg::OP_WAIT: state_ff <= mcs_pkg::ST_HOLD;
            mcs_pkg::OP_CONFIGURE: state_ff <= mcs_pkg::ST_CONFIG;
            mcs_pkg::OP_FETCH: state_ff <= mcs_pkg::ST_FETCH;
            mcs_pkg::OP_ABORT, mcs_pkg::OP_MEASURE: state_ff <= mcs_pkg::ST_ABORT;
            mcs_pkg::OP_READ: begin
              // The refusal check comes before any step of the read runs.
              if (samples_ff > 16'h0001 && buffer_nonempty) begin
                state_ff <= mcs_pkg::ST_IDLE;
              end else begin
                state_ff <= mcs_pkg::ST_ABORT;
              end
            end
            // Overlapped commands are issued and released at once.
            default: state_ff <= mcs_pkg::ST_IDLE;
          endcase
        end
        mcs_pkg::ST_ABORT: begin
          if (measure_ff) begin
            state_ff <= mcs_pkg::ST_CONFIG;
          end else if (read_ff) begin
            state_ff <= mcs_pkg::ST_INIT;
          end else begin
            state_ff <= mcs_pkg::ST_IDLE;
          end
        end
        mcs_pkg::ST_CONFIG: begin
          measure_ff <= 1'b0;
          state_ff <= read_ff ? mcs_pkg::ST_ABORT : mcs_pkg::ST_IDLE;
        end
        mcs_pkg::ST_INIT: begin
          // An ignored initiate still proceeds to the fetch step.
          state_ff <= setup_ff.cont_init ? mcs_pkg::ST_FETCH : mcs_pkg::ST_WAITIDLE;
        end
        mcs_pkg::ST_WAITIDLE: begin
          if (!engine_start_ff && engine_idle) state_ff <= mcs_pkg::ST_FETCH;
        end
        mcs_pkg::ST_FETCH: begin
          // Stays until the reading has been captured and then read from the result register.
          if (!fetch_req_ff && !result_ready_ff) begin
            read_ff <= 1'b0;
            state_ff <= mcs_pkg::ST_IDLE;
          end
        end
        mcs_pkg::ST_HOLD: begin
          if (!pending_op) state_ff <= mcs_pkg::ST_IDLE;
        end
        default: state_ff <= mcs_pkg::ST_IDLE;
      endcase
    end
  end

  // Engine command pulses.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      engine_abort_ff <= 1'b0;
      engine_start_ff <= 1'b0;
      engine_trig_ff <= 1'b0;
    end else begin
      engine_abort_ff <= state_ff == mcs_pkg::ST_ABORT;
      engine_start_ff <= (state_ff == mcs_pkg::ST_INIT ||
        (state_ff == mcs_pkg::ST_DECODE && op_ff == mcs_pkg::OP_INIT)) && !setup_ff.cont_init;
      engine_trig_ff <= state_ff == mcs_pkg::ST_DECODE && op_ff == mcs_pkg::OP_BUS_TRIG;
    end
  end

  assign engine_cmd = '{abort: engine_abort_ff, start: engine_start_ff, trig: engine_trig_ff,
    samples: samples_ff};

  // Overlapped operation tracking; a new start wins over completion in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_pending_ff <= 1'b0;
      trig_pending_ff <= 1'b0;
    end else begin
      if (engine_start_ff) begin
        init_pending_ff <= 1'b1;
      end else if (state_ff == mcs_pkg::ST_DECODE && op_ff == mcs_pkg::OP_CONT_ON && !setup_ff.cont_init) begin
        init_pending_ff <= 1'b1;
      end else if (engine_idle && !setup_ff.cont_init) begin
        init_pending_ff <= 1'b0;
      end
      if (engine_trig_ff) begin
        trig_pending_ff <= 1'b1;
      end else if (trig_settled) begin
        trig_pending_ff <= 1'b0;
      end
    end
  end

  // Setup image: configure, read buffer enable and continuous-initiation control.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_ff <= '{func: mcs_pkg::FUNC_RST, cont_init: 1'b0, trig_immediate: 1'b1, trig_count: 4'h1,
        delay_zero: 1'b1, math_en: 1'b0, buffer_en: 1'b0, autozero: 1'b1, scan_en: 1'b0};
    end else if (state_ff == mcs_pkg::ST_CONFIG) begin
      if (func_ff < mcs_pkg::FUNC_COUNT) setup_ff.func <= func_ff;
      setup_ff.cont_init <= 1'b0;
      setup_ff.trig_immediate <= 1'b1;
      setup_ff.trig_count <= 4'h1;
      setup_ff.delay_zero <= 1'b1;
      setup_ff.math_en <= 1'b0;
      setup_ff.buffer_en <= 1'b0;
      setup_ff.autozero <= 1'b1;
      setup_ff.scan_en <= 1'b0;
    end else if (state_ff == mcs_pkg::ST_DECODE && op_ff == mcs_pkg::OP_CONT_ON) begin
      setup_ff.cont_init <= 1'b1;
    end else if (state_ff == mcs_pkg::ST_DECODE && op_ff == mcs_pkg::OP_CONT_OFF) begin
      setup_ff.cont_init <= 1'b0;
    end else if (state_ff == mcs_pkg::ST_INIT) begin
      setup_ff.buffer_en <= 1'b1;
    end
  end

  assign setup = setup_ff;

  // Error capture; a new error wins over a software clear.
  always_comb begin
    set_err = 1'b0;
    set_err_code = mcs_pkg::ERR_NONE;
    if (state_ff == mcs_pkg::ST_DECODE && op_ff == mcs_pkg::OP_READ && samples_ff > 16'h0001 && buffer_nonempty) begin
      set_err = 1'b1;
      set_err_code = mcs_pkg::ERR_OUT_OF_MEMORY;
    end else if (setup_ff.cont_init && (state_ff == mcs_pkg::ST_INIT ||
        (state_ff == mcs_pkg::ST_DECODE && op_ff == mcs_pkg::OP_INIT))) begin
      set_err = 1'b1;
      set_err_code = mcs_pkg::ERR_INIT_IGNORED;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_ff <= mcs_pkg::ERR_NONE;
    end else if (set_err) begin
      error_ff <= set_err_code;
    end else if (wr_fire && awaddr_ff == mcs_pkg::REG_ERROR) begin
      error_ff <= mcs_pkg::ERR_NONE;
    end
  end

  // --------
  // Reading path: latest reading, fetch request and talker release
  // --------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latest_ff <= 32'h0000_0000;
    end else if (reading_valid) begin
      latest_ff <= reading_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_req_ff <= 1'b0;
      result_ff <= 32'h0000_0000;
      result_ready_ff <= 1'b0;
    end else begin
      if (state_ff == mcs_pkg::ST_DECODE && op_ff == mcs_pkg::OP_FETCH) begin
        fetch_req_ff <= 1'b1;
      // Only an ignored initiate fetches at once; otherwise the reading would predate the read.
      end else if ((state_ff == mcs_pkg::ST_INIT && setup_ff.cont_init) ||
          (state_ff == mcs_pkg::ST_WAITIDLE && engine_idle && !engine_start_ff)) begin
        fetch_req_ff <= 1'b1;
      end else if (fetch_req_ff && talk_sync_ff) begin
        fetch_req_ff <= 1'b0;
      end
      if (fetch_req_ff && talk_sync_ff) begin
        result_ff <= latest_ff;
        result_ready_ff <= 1'b1;
      end else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == mcs_pkg::REG_RESULT) begin
        result_ready_ff <= 1'b0;
      end
    end
  end

  // --------
  // AXI4-Lite read channel
  // --------
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= mcs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= mcs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        mcs_pkg::REG_STATUS: rdata_ff <= {24'h000000, result_ready_ff, fetch_req_ff, pending_op,
          cmd_busy, 1'b0, state_ff};
        mcs_pkg::REG_CONFIG: rdata_ff <= {17'h00000, setup_ff};
        mcs_pkg::REG_RESULT: rdata_ff <= result_ff;
        mcs_pkg::REG_SAMPLES: rdata_ff <= {16'h0000, samples_ff};
        mcs_pkg::REG_ERROR: rdata_ff <= error_ff;
        mcs_pkg::REG_CMD: rdata_ff <= 32'h0000_0000;
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= mcs_pkg::RESP_DECERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

// ===== src/mcs_pkg.sv
// Package of constants, types and register map for the measurement command sequencer.
package mcs_pkg;

  // --------
  // Register map (byte addresses)
  // --------
  localparam logic [7:0] REG_CMD = 8'h00;     // write: issue command
  localparam logic [7:0] REG_STATUS = 8'h04;  // read: sequencer state
  localparam logic [7:0] REG_CONFIG = 8'h08;  // read: setup image
  localparam logic [7:0] REG_RESULT = 8'h0c;  // read: reading sent to host
  localparam logic [7:0] REG_SAMPLES = 8'h10; // read/write: sample count
  localparam logic [7:0] REG_ERROR = 8'h14;   // read: last error code, write clears

  // --------
  // Field positions and reset values
  // --------
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_FUNC_LSB = 8;
  localparam logic [15:0] SAMPLES_RST = 16'h0001;
  localparam logic [31:0] ERR_NONE = 32'h0000_0000;
  localparam logic [31:0] ERR_OUT_OF_MEMORY = 32'hffff_ff1f; // -225
  localparam logic [31:0] ERR_INIT_IGNORED = 32'hffff_fe5f;  // -417 style init-ignored
  localparam logic [3:0] FUNC_COUNT = 4'hb;
  localparam logic [3:0] FUNC_RST = 4'h3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // --------
  // Command encodings
  // --------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ABORT = 4'h1,
    OP_INIT = 4'h2,
    OP_CONT_ON = 4'h3,
    OP_CONT_OFF = 4'h4,
    OP_BUS_TRIG = 4'h5,
    OP_WAIT = 4'h6,
    OP_CONFIGURE = 4'h7,
    OP_CONF_QUERY = 4'h8,
    OP_FETCH = 4'h9,
    OP_READ = 4'ha,
    OP_MEASURE = 4'hb,
    OP_CLEAR_BUF = 4'hc
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DECODE = 3'b001,
    ST_ABORT = 3'b010,
    ST_CONFIG = 3'b011,
    ST_INIT = 3'b100,
    ST_WAITIDLE = 3'b101,
    ST_FETCH = 3'b110,
    ST_HOLD = 3'b111
  } seq_state_t;

  // Setup image shown in the configuration register.
  typedef struct packed {
    logic [3:0] func;
    logic cont_init;
    logic trig_immediate;
    logic [3:0] trig_count;
    logic delay_zero;
    logic math_en;
    logic buffer_en;
    logic autozero;
    logic scan_en;
  } setup_t;

  // Command pulse towards the measurement engine.
  typedef struct packed {
    logic abort;
    logic start;
    logic trig;
    logic [15:0] samples;
  } engine_cmd_t;

endpackage

// ===== tb/engine_model.sv
// Behavioural measurement engine that answers the sequencer's start, trigger and abort pulses.
`timescale 1ns/1ps
module engine_model #(parameter int LAT = 20, parameter int TLAT = 12) (
  input wire logic aclk, // clock
  input wire logic aresetn, // synchronous reset, active low
  input wire mcs_pkg::engine_cmd_t engine_cmd, // pulses from the sequencer
  output logic engine_idle, // engine idle level
  output logic trig_settled, // trigger position settled
  output logic reading_valid, // new reading strobe
  output logic [31:0] reading_data // reading value
);
  int bcnt;
  int tcnt;
  int left;
  logic [31:0] val_ff;
  // Busy and unsettled show in the pulse's own cycle, as a real engine would not lag.
  assign engine_idle = (bcnt == 0) && !engine_cmd.start;
  assign trig_settled = (tcnt == 0) && !engine_cmd.trig;
  always_ff @(posedge aclk) begin
    reading_valid <= 1'b0;
    // Outside a strobe the value keeps moving so a late capture cannot pass.
    reading_data <= ~reading_data;
    if (!aresetn) begin
      bcnt <= 0;
      tcnt <= 0;
      left <= 0;
      val_ff <= 32'h3c00_0001;
      reading_data <= 32'h0;
    end else begin
      if (engine_cmd.trig) tcnt <= TLAT;
      else if (tcnt > 0) tcnt <= tcnt - 1;
      if (engine_cmd.abort) bcnt <= 0;
      else if (engine_cmd.start) begin
        bcnt <= LAT;
        left <= int'(engine_cmd.samples);
      end else if (bcnt == 1) begin
        bcnt <= (left > 1) ? LAT : 0;
        left <= left - 1;
        reading_valid <= 1'b1;
        reading_data <= val_ff;
        val_ff <= val_ff + 32'h0000_0101;
      end else if (bcnt > 0) bcnt <= bcnt - 1;
    end
  end
endmodule

// ===== tb/mcs_checker.sv
// Concurrent checks on the sequencer's ports.
`timescale 1ns/1ps
module mcs_checker (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic engine_idle, // engine idle
  input wire logic trig_settled, // trigger settled
  input wire mcs_pkg::engine_cmd_t engine_cmd, // engine pulses
  input wire mcs_pkg::setup_t setup, // setup image
  input wire logic pending_op // overlapped work in progress
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence all_quiet;
    engine_idle && trig_settled && !setup.cont_init;
  endsequence
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  init_ignored_a: assert property (engine_cmd.start |-> !setup.cont_init)
    else $error("start in continuous");
  trig_pending_a: assert property (engine_cmd.trig |-> ##[0:2] pending_op)
    else $error("trigger not pending");
  pending_drop_a: assert property (pending_op ##0 all_quiet[*4] |-> ##[0:3] !pending_op)
    else $error("pending stuck");
  setup_fixed_a: assert property (setup.trig_immediate && setup.trig_count == 4'h1 && setup.delay_zero &&
    !setup.math_en && setup.autozero && !setup.scan_en) else $error("setup drift");
  func_range_a: assert property (setup.func < mcs_pkg::FUNC_COUNT) else $error("function out of range");
  start_pulse_a: assert property (engine_cmd.start |=> !engine_cmd.start) else $error("start too long");
endmodule
bind measurement_command_sequencer mcs_checker i_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .engine_idle,
  .trig_settled, .engine_cmd, .setup, .pending_op);

// ===== tb/tb_top.sv
// Self-checking bench for the measurement command sequencer.
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, talk_addressed, buffer_nonempty;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic engine_idle, trig_settled, reading_valid, pending_op;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, reading_data, last_rd, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  mcs_pkg::engine_cmd_t engine_cmd;
  mcs_pkg::setup_t setup;
  int err_count, n_checks, cyc, rd_n, n, smp;
  int ev_q[$];
  measurement_command_sequencer i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready(1'b1), .talk_addressed, .engine_idle, .trig_settled, .reading_valid,
    .reading_data, .buffer_nonempty, .engine_cmd, .setup, .pending_op);
  engine_model i_eng (.aclk, .aresetn, .engine_cmd, .engine_idle, .trig_settled, .reading_valid, .reading_data);
  // --------
  // Reference model and bus tasks
  // --------
  // Engine abort and start pulses and readings are logged so order and freshness are judged from what the engine saw.
  always @(posedge aclk) begin
    cyc++;
    if (aresetn && engine_cmd.abort === 1'b1) ev_q.push_back(1);
    if (aresetn && engine_cmd.start === 1'b1) ev_q.push_back(2);
    if (reading_valid === 1'b1) begin
      last_rd = reading_data;
      rd_n++;
    end
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] cfg(input logic [3:0] f, input logic c, input logic b);
    mcs_pkg::setup_t s;
    s = '{f, c, 1'b1, 4'h1, 1'b1, 1'b0, b, 1'b1, 1'b0};
    return {17'h0, s};
  endfunction
  // Ready and valid are looked at mid-cycle, where they equal their value at the next rising edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    logic ar_t, r_t;
    r_t = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      dv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
  endtask
  task automatic cmd(input logic [3:0] op, input logic [3:0] f);
    axi_wr(mcs_pkg::REG_CMD, {20'h0, f, 4'h0, op}, r);
  endtask
  task automatic get_res(output logic [31:0] dv);
    dv = 32'h0;
    while (dv[7] !== 1'b1) axi_rd(mcs_pkg::REG_STATUS, dv, r);
    axi_rd(mcs_pkg::REG_RESULT, dv, r);
  endtask
  // --------
  // Scenarios
  // --------
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, talk_addressed, buffer_nonempty} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    void'($urandom(32'h572b8205));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(mcs_pkg::REG_SAMPLES, d, r);
    chk("samples_rst", d, {16'h0, mcs_pkg::SAMPLES_RST});
    axi_rd(mcs_pkg::REG_CONFIG, d, r);
    chk("config_rst", d, cfg(mcs_pkg::FUNC_RST, 1'b0, 1'b0));
    axi_rd(mcs_pkg::REG_CMD, d, r);
    chk("cmd_read", d, 32'h0);
    axi_rd(8'h18, d, r);
    chk("unmapped", {30'h0, r}, {30'h0, mcs_pkg::RESP_DECERR});
    axi_wr(mcs_pkg::REG_STATUS, 32'h0, r);
    chk("ro_write", {30'h0, r}, {30'h0, mcs_pkg::RESP_SLVERR});
    cmd(mcs_pkg::OP_INIT, 4'h0);
    cmd(mcs_pkg::OP_WAIT, 4'h0);
    cmd(mcs_pkg::OP_NOP, 4'h0);
    @(negedge aclk);
    chk("wait_init", {31'h0, engine_idle}, 32'h1);
    chk("pending_clr", {31'h0, pending_op}, 32'h0);
    @(posedge aclk);
    cmd(mcs_pkg::OP_BUS_TRIG, 4'h0);
    cmd(mcs_pkg::OP_WAIT, 4'h0);
    cmd(mcs_pkg::OP_NOP, 4'h0);
    @(negedge aclk);
    chk("wait_trig", {31'h0, trig_settled}, 32'h1);
    @(posedge aclk);
    n = ev_q.size();
    cmd(mcs_pkg::OP_FETCH, 4'h0);
    repeat (4) axi_rd(mcs_pkg::REG_STATUS, d, r);
    chk("no_talk", {31'h0, d[7]}, 32'h0);
    talk_addressed <= 1'b1;
    get_res(d);
    chk("fetch", d, last_rd);
    cmd(mcs_pkg::OP_FETCH, 4'h0);
    get_res(d);
    chk("refetch", d, last_rd);
    axi_rd(mcs_pkg::REG_CONFIG, d, r);
    chk("fetch_setup", d, cfg(mcs_pkg::FUNC_RST, 1'b0, 1'b0));
    chk("fetch_notrig", ev_q.size(), n);
    smp = $urandom_range(9, 2);
    axi_wr(mcs_pkg::REG_SAMPLES, smp, r);
    axi_rd(mcs_pkg::REG_SAMPLES, d, r);
    chk("samples_rw", d, smp);
    chk("samples_out", {16'h0, engine_cmd.samples}, smp);
    n = rd_n;
    cmd(mcs_pkg::OP_READ, 4'h0);
    get_res(d);
    chk("read", d, last_rd);
    chk("read_new", rd_n, n + smp);
    chk("read_order", ev_q[$-1] * 4 + ev_q[$], 6);
    buffer_nonempty <= 1'b1;
    n = ev_q.size();
    cmd(mcs_pkg::OP_READ, 4'h0);
    axi_rd(mcs_pkg::REG_ERROR, d, r);
    chk("refused", d, mcs_pkg::ERR_OUT_OF_MEMORY);
    chk("refused_quiet", ev_q.size(), n);
    buffer_nonempty <= 1'b0;
    axi_wr(mcs_pkg::REG_ERROR, 32'h0, r);
    axi_rd(mcs_pkg::REG_ERROR, d, r);
    chk("err_clear", d, mcs_pkg::ERR_NONE);
    cmd(mcs_pkg::OP_CONT_ON, 4'h0);
    cmd(mcs_pkg::OP_INIT, 4'h0);
    axi_rd(mcs_pkg::REG_ERROR, d, r);
    chk("init_ignored", d, mcs_pkg::ERR_INIT_IGNORED);
    axi_rd(mcs_pkg::REG_CONFIG, d, r);
    chk("cont_on", d, cfg(mcs_pkg::FUNC_RST, 1'b1, 1'b1));
    cmd(mcs_pkg::OP_READ, 4'h0);
    get_res(d);
    chk("read_cont", d, last_rd);
    n = ev_q.size();
    cmd(mcs_pkg::OP_ABORT, 4'h0);
    do axi_rd(mcs_pkg::REG_STATUS, d, r); while (d[4] !== 1'b0);
    chk("abort", ev_q.size(), n + 1);
    for (int f = 0; f < 11; f++) begin
      cmd(mcs_pkg::OP_CONFIGURE, f[3:0]);
      // The write answer precedes the command's steps, so wait for idle first.
      do axi_rd(mcs_pkg::REG_STATUS, d, r); while (d[4] !== 1'b0);
      axi_rd(mcs_pkg::REG_CONFIG, d, r);
      chk("configure", d, cfg(f[3:0], 1'b0, 1'b0));
    end
    cmd(mcs_pkg::OP_MEASURE, 4'h5);
    get_res(d);
    chk("measure", d, last_rd);
    chk("measure_order", ev_q[$-1] * 4 + ev_q[$], 6);
    axi_rd(mcs_pkg::REG_CONFIG, d, r);
    chk("measure_cfg", d, cfg(4'h5, 1'b0, 1'b1));
    conclude();
  end
endmodule
